// File: core/dcm_pkg.sv
`default_nettype none

package dcm_pkg;

    // Digit layout
    localparam int DIGIT_W = 4;
    localparam int ACC_DIGITS = 20;
    localparam int READ_DIGITS = 12;
    localparam int FRAC_DIGITS = 8;
    localparam int OPD_DIGITS = 10;

    // Multiplying cycle timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int ACC_CYCLE_MS = 200;
    localparam int ACC_CYCLE_CLKS = ACC_CYCLE_MS * 1000000 / CLK_PERIOD_NS;

    // Decimal shift values, in decimal places
    localparam int SHIFT_MAX = 8;
    localparam int SHIFT_A = 8;
    localparam int SHIFT_B = 7;
    localparam int SHIFT_C = 5;
    localparam int SHIFT_D = 2;

    typedef enum logic [1:0] {SRC_KEYS, SRC_TOTALS, SRC_PRODUCT} dcm_src_t;
    typedef enum logic [1:0] {OP_PRINT, OP_NONADD, OP_ADD, OP_SUB} dcm_op_t;
    typedef enum logic [1:0] {SHIFT_SEL_A, SHIFT_SEL_B, SHIFT_SEL_C, SHIFT_SEL_D} dcm_shift_t;

    // One machine cycle as programmed for the current position
    typedef struct packed {
        logic load_mplier;
        logic load_mcand;
        dcm_src_t src;
        dcm_op_t op;
        logic product;
    } dcm_cycle_t;

    // Amount handed to the host add path
    typedef struct packed {
        logic valid;
        dcm_op_t op;
        logic [READ_DIGITS*DIGIT_W-1:0] amount;
    } dcm_totals_t;

endpackage

`default_nettype wire

// File: core/dcm_component_gen.sv
`default_nettype none

module dcm_component_gen #(
    parameter int DIGITS = dcm_pkg::OPD_DIGITS
) (
    // Selected multiplier digit
    input wire logic [3:0] mdigit,
    // Whole multiplicand
    input wire logic [DIGITS*4-1:0] mcand,
    // Units and tens components
    output logic [DIGITS*4-1:0] right_comp,
    output logic [DIGITS*4-1:0] left_comp
);

    // Right and left tables for multiplier rows 1..9; row 0 is never selected
    function automatic logic [3:0] table_entry(input logic left, input logic [3:0] m, input logic [3:0] d);
        logic [7:0] p;
        p = 8'(m) * 8'(d);
        if (m == 4'h0 || m > 4'h9 || d > 4'h9) begin
            return 4'h0;
        end
        return left ? 4'(p / 8'h0A) : 4'(p % 8'h0A);
    endfunction

    // Both components of a digit product fit one digit each, since 9 x 9 is two digits
    for (genvar i = 0; i < DIGITS; i++) begin : g_digit
        assign right_comp[i*4 +: 4] = table_entry(1'b0, mdigit, mcand[i*4 +: 4]);
        assign left_comp[i*4 +: 4] = table_entry(1'b1, mdigit, mcand[i*4 +: 4]);
    end

endmodule

`default_nettype wire

// File: core/dcm_bcd_adder.sv
`default_nettype none

module dcm_bcd_adder #(
    parameter int DIGITS = dcm_pkg::ACC_DIGITS
) (
    // Operands
    input wire logic [DIGITS*4-1:0] a,
    input wire logic [DIGITS*4-1:0] b,
    // Decimal sum, top carry dropped
    output logic [DIGITS*4-1:0] sum
);

    logic [DIGITS:0] carry;
    assign carry[0] = 1'b0;

    for (genvar i = 0; i < DIGITS; i++) begin : g_digit
        logic [4:0] raw;
        assign raw = 5'(a[i*4 +: 4]) + 5'(b[i*4 +: 4]) + 5'(carry[i]);
        assign carry[i+1] = raw > 5'h09;
        assign sum[i*4 +: 4] = carry[i+1] ? 4'(raw - 5'h0A) : raw[3:0];
    end

endmodule

`default_nettype wire

// File: core/dcm_core.sv
`default_nettype none

module dcm_core #(
    parameter int OPD_DIGITS = dcm_pkg::OPD_DIGITS,
    parameter int CYCLE_CLKS = dcm_pkg::ACC_CYCLE_CLKS
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET,

    // Machine cycle from the host
    input wire logic CYCLE_VALID,
    input wire dcm_pkg::dcm_cycle_t CYCLE,

    // Factor sources
    input wire logic [OPD_DIGITS*4-1:0] KEY_AMOUNT,
    input wire logic [OPD_DIGITS*4-1:0] STORED_AMOUNT,

    // Multiplication control
    input wire logic MULTIPLY_ARM,
    input wire dcm_pkg::dcm_shift_t DECIMAL_SHIFT,
    input wire logic MULT_START,
    input wire logic FRAC_CLEAR,

    // Amount to the host add path
    output dcm_pkg::dcm_totals_t TOTALS_OUT,

    // Status
    output logic BUSY,
    output logic PRODUCT_READY,
    output logic ARMED,

    // Operand store view
    output logic [OPD_DIGITS*4-1:0] MULTIPLIER_OPERAND,
    output logic [OPD_DIGITS*4-1:0] MULTIPLICAND_OPERAND
);

    localparam int DW = dcm_pkg::DIGIT_W;
    localparam int OPD_W = OPD_DIGITS * DW;
    localparam int ACC_W = dcm_pkg::ACC_DIGITS * DW;
    localparam int READ_W = dcm_pkg::READ_DIGITS * DW;
    localparam int FRAC_W = dcm_pkg::FRAC_DIGITS * DW;
    localparam int IDX_W = $clog2(OPD_DIGITS);
    localparam int CNT_W = $clog2(CYCLE_CLKS + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CYCLE_CLKS - 1);

    typedef enum logic [1:0] {ST_IDLE, ST_RIGHT, ST_LEFT, ST_HOLD} dcm_state_t;

    typedef struct packed {
        dcm_state_t st;
        logic [ACC_W-1:0] acc;
        logic [OPD_W-1:0] mplier;
        logic [OPD_W-1:0] mcand;
        logic [OPD_W-1:0] stage_mp;
        logic [OPD_W-1:0] stage_mc;
        logic pend_mp;
        logic pend_mc;
        logic armed;
        dcm_pkg::dcm_shift_t shift;
        logic [IDX_W-1:0] idx;
        logic [CNT_W-1:0] cnt;
        dcm_pkg::dcm_totals_t totals;
    } dcm_core_state_t;

    dcm_core_state_t r;
    dcm_core_state_t next_r;

    // Lowest nonzero digit at or above a start position
    function automatic logic [IDX_W:0] first_nz(input logic [OPD_W-1:0] v, input int from);
        logic [IDX_W:0] res;
        res = '0;
        for (int i = OPD_DIGITS - 1; i >= 0; i--) begin
            if (i >= from && v[i*DW +: DW] != 4'h0) begin
                res = {1'b1, IDX_W'(i)};
            end
        end
        return res;
    endfunction

    // Columns skipped at the right of the accumulator
    function automatic int shift_offset(input dcm_pkg::dcm_shift_t s);
        unique case (s)
            dcm_pkg::SHIFT_SEL_A: return dcm_pkg::SHIFT_MAX - dcm_pkg::SHIFT_A;
            dcm_pkg::SHIFT_SEL_B: return dcm_pkg::SHIFT_MAX - dcm_pkg::SHIFT_B;
            dcm_pkg::SHIFT_SEL_C: return dcm_pkg::SHIFT_MAX - dcm_pkg::SHIFT_C;
            dcm_pkg::SHIFT_SEL_D: return dcm_pkg::SHIFT_MAX - dcm_pkg::SHIFT_D;
        endcase
    endfunction

    logic [3:0] cur_digit;
    logic [OPD_W-1:0] right_comp;
    logic [OPD_W-1:0] left_comp;
    logic [OPD_W-1:0] sel_comp;
    logic [ACC_W+OPD_W-1:0] wide;
    logic [ACC_W-1:0] addend;
    logic [ACC_W-1:0] sum;
    logic [READ_W-1:0] read_word;
    logic [OPD_W-1:0] src_amount;
    logic [IDX_W:0] start_nz;
    logic [IDX_W:0] step_nz;
    logic tick;
    logic busy;
    int pos;

    assign cur_digit = r.mplier[r.idx*DW +: DW];

    dcm_component_gen #(
        .DIGITS(OPD_DIGITS)
    ) u_comp (
        .mdigit(cur_digit),
        .mcand(r.mcand),
        .right_comp(right_comp),
        .left_comp(left_comp)
    );

    always_comb begin
        sel_comp = (r.st == ST_LEFT) ? left_comp : right_comp;
        pos = shift_offset(r.shift) + int'(r.idx);
        if (r.st == ST_LEFT) begin
            pos = pos + 1;
        end
    end

    // Columns beyond the top are dropped with the shift
    assign wide = {{ACC_W{1'b0}}, sel_comp} << (DW * pos);
    assign addend = wide[ACC_W-1:0];

    dcm_bcd_adder #(
        .DIGITS(dcm_pkg::ACC_DIGITS)
    ) u_add (
        .a(r.acc),
        .b(addend),
        .sum(sum)
    );

    assign read_word = r.acc[ACC_W-1 -: READ_W];

    always_comb begin
        unique case (CYCLE.src)
            dcm_pkg::SRC_KEYS: src_amount = KEY_AMOUNT;
            dcm_pkg::SRC_TOTALS: src_amount = STORED_AMOUNT;
            dcm_pkg::SRC_PRODUCT: src_amount = read_word[OPD_W-1:0];
            default: src_amount = '0;
        endcase
    end

    assign start_nz = first_nz(r.mplier, 0);
    assign step_nz = first_nz(r.mplier, int'(r.idx) + 1);

    assign busy = (r.st == ST_RIGHT) || (r.st == ST_LEFT);

    // Multiplying cycle rate as a one-clock enable
    assign tick = busy && (r.cnt == CNT_LAST);

    always_comb begin
        next_r = r;
        next_r.totals.valid = 1'b0;

        // Stage to store, then the stage falls back to zero
        if (r.pend_mp) begin
            next_r.mplier = r.stage_mp;
            next_r.stage_mp = '0;
            next_r.pend_mp = 1'b0;
        end
        if (r.pend_mc) begin
            next_r.mcand = r.stage_mc;
            next_r.stage_mc = '0;
            next_r.pend_mc = 1'b0;
        end

        if (busy) begin
            next_r.cnt = tick ? '0 : r.cnt + 1'b1;
        end else begin
            next_r.cnt = '0;
        end

        if (MULTIPLY_ARM && !busy) begin
            next_r.armed = 1'b1;
            next_r.shift = DECIMAL_SHIFT;
        end

        unique case (r.st)
            ST_RIGHT: begin
                if (tick) begin
                    next_r.acc = sum;
                    next_r.st = ST_LEFT;
                end
            end
            ST_LEFT: begin
                if (tick) begin
                    next_r.acc = sum;
                    if (step_nz[IDX_W]) begin
                        next_r.idx = step_nz[IDX_W-1:0];
                        next_r.st = ST_RIGHT;
                    end else begin
                        next_r.st = ST_HOLD;
                    end
                end
            end
            ST_IDLE, ST_HOLD: begin
                if (MULT_START && r.armed) begin
                    // Start wins over a machine cycle in the same clock
                    next_r.armed = 1'b0;
                    if (start_nz[IDX_W]) begin
                        next_r.idx = start_nz[IDX_W-1:0];
                        next_r.st = ST_RIGHT;
                    end else begin
                        next_r.st = ST_HOLD;
                    end
                end else begin
                    if (FRAC_CLEAR) begin
                        next_r.acc[FRAC_W-1:0] = '0;
                    end
                    if (CYCLE_VALID) begin
                        if (CYCLE.load_mplier) begin
                            next_r.mplier = '0;
                            next_r.stage_mp = src_amount;
                            next_r.pend_mp = 1'b1;
                        end
                        if (CYCLE.load_mcand) begin
                            next_r.mcand = '0;
                            next_r.stage_mc = src_amount;
                            next_r.pend_mc = 1'b1;
                        end
                        if (CYCLE.product) begin
                            // Repeat or motor bar cycle assumed; no result-key path here
                            next_r.totals.valid = 1'b1;
                            next_r.totals.op = CYCLE.op;
                            next_r.totals.amount = read_word;
                            next_r.acc = '0;
                            next_r.st = ST_IDLE;
                        end else if (CYCLE.load_mplier || CYCLE.load_mcand) begin
                            next_r.totals.valid = 1'b1;
                            next_r.totals.op = CYCLE.op;
                            next_r.totals.amount = {{(READ_W - OPD_W){1'b0}}, src_amount};
                        end
                    end
                end
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign TOTALS_OUT = r.totals;
    assign BUSY = busy;
    assign PRODUCT_READY = (r.st == ST_HOLD);
    assign ARMED = r.armed;
    assign MULTIPLIER_OPERAND = r.mplier;
    assign MULTIPLICAND_OPERAND = r.mcand;

endmodule

`default_nettype wire

// File: testbench/dcm_host_model.sv
`default_nettype none
module dcm_host_model (
    // Clock
    input wire logic clk,
    // Machine cycle to the block
    output logic cycle_valid,
    output dcm_pkg::dcm_cycle_t cycle
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        cycle_valid = 1'b0;
        cycle = '0;
    end
    // Repeat or motor-bar cycles only; a result-key start would spoil the transfer
    task automatic issue(input logic lm, lc, input dcm_pkg::dcm_src_t src, input dcm_pkg::dcm_op_t op, input logic pr);
        @(negedge clk);
        cycle_valid = 1'b1;
        cycle = {lm, lc, src, op, pr};
        @(negedge clk);
        cycle_valid = 1'b0;
        // Fields are dead outside the valid cycle, so show them inverted
        cycle = ~cycle;
    endtask
endmodule
`default_nettype wire

// File: testbench/dcm_core_monitor.sv
`default_nettype none
module dcm_core_monitor #(
    parameter int OPD_DIGITS = 10,
    parameter int CYCLE_CLKS = 4
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // Inputs watched
    input wire logic CYCLE_VALID,
    input wire dcm_pkg::dcm_cycle_t CYCLE,
    input wire logic [OPD_DIGITS*4-1:0] KEY_AMOUNT,
    input wire logic MULT_START,
    // Outputs watched
    input wire dcm_pkg::dcm_totals_t TOTALS_OUT,
    input wire logic BUSY,
    input wire logic PRODUCT_READY,
    input wire logic ARMED,
    input wire logic [OPD_DIGITS*4-1:0] MULTIPLIER_OPERAND
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int BUSY_MAX = 2 * CYCLE_CLKS * OPD_DIGITS;
    logic take;
    logic take_mp;
    int busy_cnt;
    assign take = CYCLE_VALID && !BUSY && !(MULT_START && ARMED);
    assign take_mp = take && CYCLE.load_mplier;
    always_ff @(posedge CLK) begin
        busy_cnt <= (RESET || !BUSY) ? 0 : busy_cnt + 1;
    end
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RESET);
    a_busy_cause: assert property ($rose(BUSY) |-> $past(MULT_START) && $past(ARMED))
        else $error("busy without start");
    a_digit_pair: assert property ($rose(BUSY) |-> BUSY [*8])
        else $error("digit shorter than two cycles");
    a_busy_bound: assert property (busy_cnt <= BUSY_MAX)
        else $error("multiplying too long");
    a_zero_skip: assert property (MULT_START && ARMED && !BUSY && MULTIPLIER_OPERAND == '0
        |=> PRODUCT_READY && !BUSY) else $error("zero multiplier not skipped");
    a_done_ready: assert property (!$past(RESET) && $fell(BUSY) |-> PRODUCT_READY)
        else $error("no product after multiplying");
    a_busy_refuse: assert property (BUSY && CYCLE_VALID |=> !TOTALS_OUT.valid)
        else $error("cycle taken while busy");
    a_load_zero: assert property (take_mp |=> MULTIPLIER_OPERAND == '0)
        else $error("half not zeroed before load");
    a_factor_hold: assert property (!$past(RESET) && !$past(take_mp) && !$past(take_mp, 2)
        |-> $stable(MULTIPLIER_OPERAND)) else $error("factor lost");
    a_key_pass: assert property (take && !CYCLE.product && (CYCLE.load_mplier || CYCLE.load_mcand) && CYCLE.src == dcm_pkg::SRC_KEYS
        |=> TOTALS_OUT.valid && TOTALS_OUT.amount == 48'($past(KEY_AMOUNT))) else $error("load not passed on");
    a_product_out: assert property (take && CYCLE.product
        |=> TOTALS_OUT.valid && !PRODUCT_READY && TOTALS_OUT.op == $past(CYCLE.op)) else $error("bad product cycle");
endmodule
bind dcm_core dcm_core_monitor #(.OPD_DIGITS(OPD_DIGITS), .CYCLE_CLKS(CYCLE_CLKS)) u_mon (
    .CLK(CLK), .RESET(RESET), .CYCLE_VALID(CYCLE_VALID), .CYCLE(CYCLE), .KEY_AMOUNT(KEY_AMOUNT),
    .MULT_START(MULT_START), .TOTALS_OUT(TOTALS_OUT), .BUSY(BUSY), .PRODUCT_READY(PRODUCT_READY),
    .ARMED(ARMED), .MULTIPLIER_OPERAND(MULTIPLIER_OPERAND)
);
`default_nettype wire

// File: testbench/tb_decimal_component_multiplier.sv
`default_nettype none
module tb_decimal_component_multiplier;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic arm = 1'b0, start = 1'b0, fclr = 1'b0;
    logic [39:0] key = 40'h0, stored = 40'h0;
    dcm_pkg::dcm_shift_t shift = dcm_pkg::SHIFT_SEL_A;
    dcm_pkg::dcm_cycle_t cyc;
    dcm_pkg::dcm_totals_t tot;
    logic cyc_valid, busy, ready, armed;
    logic [39:0] mplier, mcand;
    int fail_count = 0, checks_done = 0;
    always #25 clk = ~clk;
    dcm_host_model u_host (.clk(clk), .cycle_valid(cyc_valid), .cycle(cyc));
    // Short multiplying cycle keeps the run brief
    dcm_core #(.CYCLE_CLKS(4)) u_dut (
        .CLK(clk), .RESET(rst), .CYCLE_VALID(cyc_valid), .CYCLE(cyc), .KEY_AMOUNT(key),
        .STORED_AMOUNT(stored), .MULTIPLY_ARM(arm), .DECIMAL_SHIFT(shift), .MULT_START(start),
        .FRAC_CLEAR(fclr), .TOTALS_OUT(tot), .BUSY(busy), .PRODUCT_READY(ready), .ARMED(armed),
        .MULTIPLIER_OPERAND(mplier), .MULTIPLICAND_OPERAND(mcand)
    );
    task automatic chk(input logic [47:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // The unused source carries a decoy so a wrong pick shows
    task automatic load(input logic lm, input dcm_pkg::dcm_src_t src, input logic [39:0] amt);
        key = (src == dcm_pkg::SRC_KEYS) ? amt : 40'h0000000321;
        stored = (src == dcm_pkg::SRC_KEYS) ? 40'h0000000654 : amt;
        u_host.issue(lm, !lm, src, dcm_pkg::OP_ADD, 1'b0);
        chk(48'(tot.valid), 48'h1);
        chk(tot.amount, 48'(amt));
        chk(48'(lm ? mplier : mcand), 48'h0);
        @(negedge clk);
        chk(48'(lm ? mplier : mcand), 48'(amt));
    endtask
    task automatic mult(input dcm_pkg::dcm_shift_t s, input int busy_clks);
        int n;
        n = 0;
        shift = s;
        arm = 1'b1;
        @(negedge clk);
        arm = 1'b0;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        for (int k = 0; k < 300 && !(ready === 1'b1 && busy === 1'b0); k++) begin
            n += (busy === 1'b1);
            @(negedge clk);
        end
        chk(48'(ready), 48'h1);
        if (ready !== 1'b1) report_and_stop();
        chk(48'(n), 48'(busy_clks));
    endtask
    task automatic product(input dcm_pkg::dcm_op_t op, input logic lc, input logic [47:0] exp);
        u_host.issue(1'b0, lc, dcm_pkg::SRC_PRODUCT, op, 1'b1);
        chk(tot.amount, exp);
        chk(48'(tot.op), 48'(op));
        chk(48'(ready), 48'h0);
    endtask
    task automatic t_operands;
        chk(48'(busy | ready | armed | tot.valid), 48'h0);
        load(1'b1, dcm_pkg::SRC_KEYS, 40'h0000000709);
        load(1'b0, dcm_pkg::SRC_TOTALS, 40'h0006253754);
        chk(48'(mplier), 48'h709);
        $display("operands done");
    endtask
    task automatic t_multiply;
        fork
            mult(dcm_pkg::SHIFT_SEL_D, 16);
            begin
                repeat (3) @(negedge clk);
                key = 40'h1;
                u_host.issue(1'b0, 1'b1, dcm_pkg::SRC_KEYS, dcm_pkg::OP_ADD, 1'b0);
            end
        join
        chk(48'(mcand), 48'h6253754);
        product(dcm_pkg::OP_NONADD, 1'b1, 48'h000044339115);
        @(negedge clk);
        chk(48'(mcand), 48'h0044339115);
        product(dcm_pkg::OP_SUB, 1'b0, 48'h0);
        $display("multiply done");
    endtask
    task automatic t_digits;
        load(1'b1, dcm_pkg::SRC_KEYS, 40'h1234567890);
        load(1'b0, dcm_pkg::SRC_TOTALS, 40'h9999999999);
        mult(dcm_pkg::SHIFT_SEL_A, 72);
        product(dcm_pkg::OP_ADD, 1'b0, 48'h123456788987);
        $display("digits done");
    endtask
    task automatic t_frac;
        load(1'b1, dcm_pkg::SRC_KEYS, 40'h1);
        load(1'b0, dcm_pkg::SRC_TOTALS, 40'h0099999999);
        mult(dcm_pkg::SHIFT_SEL_A, 8);
        fclr = 1'b1;
        @(negedge clk);
        fclr = 1'b0;
        load(1'b0, dcm_pkg::SRC_KEYS, 40'h1);
        mult(dcm_pkg::SHIFT_SEL_A, 8);
        load(1'b1, dcm_pkg::SRC_KEYS, 40'h0);
        mult(dcm_pkg::SHIFT_SEL_A, 0);
        product(dcm_pkg::OP_ADD, 1'b0, 48'h0);
        $display("fraction done");
    endtask
    initial begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        t_operands();
        t_multiply();
        t_digits();
        t_frac();
        report_and_stop();
    end
endmodule
`default_nettype wire
